// >>> common/rcis_pkg.sv
// ==================================================
// shared constants for the reset cause and init block
package rcis_pkg;
  // ==================================================
  // clock and timing
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned CLK_NS     = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RSTD_MS    = 48;   // release delay after a full reset
  localparam int unsigned RSTD_CYC   = RSTD_MS * (CLK_HZ / 1000);
  localparam int unsigned LVR_US     = 60;   // least low-supply time to qualify
  localparam int unsigned LVR_CYC    = LVR_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SRESET_US  = 40;   // delay before a software reset
  localparam int unsigned SRESET_CYC = SRESET_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SST_NS     = 320;  // restart after a sleep time-out
  localparam int unsigned SST_CYC    = (SST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WDT_CYC    = 262_144;  // watchdog period, 2^18
  // ==================================================
  // counter widths
  localparam int DLY_W = 24;
  localparam int WDT_W = 18;
  localparam int LV_W  = 16;
  localparam int TB_W  = 16;
  // ==================================================
  // register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_WDT    = 8'h08;
  localparam logic [7:0] ADDR_VSEL   = 8'h0c;
  localparam logic [7:0] ADDR_EVT    = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_STATE  = 8'h18;
  localparam logic [7:0] ADDR_WCNT   = 8'h1c;
  // ==================================================
  // reset values and codes
  localparam logic [7:0] WDT_POR  = 8'h53;
  localparam logic [7:0] VSEL_POR = 8'h55;
  localparam logic [4:0] KEY_EN_A = 5'h15;
  localparam logic [4:0] KEY_EN_B = 5'h0a;
  localparam logic [7:0] VSEL_A   = 8'h55;
  localparam logic [7:0] VSEL_B   = 8'h33;
  localparam logic [7:0] VSEL_C   = 8'h99;
  localparam logic [7:0] VSEL_D   = 8'haa;
  // ==================================================
  // event bit positions
  localparam int EVT_W       = 6;
  localparam int EV_RELEASE  = 0;
  localparam int EV_WDT_RUN  = 1;
  localparam int EV_WDT_IDLE = 2;
  localparam int EV_LVR      = 3;
  localparam int EV_VSEL     = 4;
  localparam int EV_KEY      = 5;
  // ==================================================
  // enumerations
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_PEND = 2'h1,
    ST_HOLD = 2'h3,
    ST_PART = 2'h2
  } rcis_state_e;
  typedef enum logic [1:0] {
    MODE_FAST  = 2'h0,
    MODE_SLOW  = 2'h1,
    MODE_IDLE  = 2'h3,
    MODE_SLEEP = 2'h2
  } rcis_mode_e;
endpackage

// >>> common/rcis_cnt_if.sv
`timescale 1ns/1ps
// ==================================================
// owner-to-counter bundle
interface rcis_cnt_if #(parameter int W = 16);
  logic         clear;
  logic         run;
  logic [W-1:0] limit;
  logic [W-1:0] count;
  logic         hit;
  modport owner   (output clear, run, limit, input count, hit);
  modport counter (input clear, run, limit, output count, hit);
endinterface

// >>> verilog/rcis_counter.sv
`timescale 1ns/1ps
// ==================================================
// up counter that stops at its limit
module rcis_counter (
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  rcis_cnt_if.counter cnt
);
  // clear wins over counting
  always_ff @(posedge i_clk) begin
    if (i_reset || cnt.clear) begin
      cnt.count <= '0;
    end else if (cnt.run && !cnt.hit) begin
      cnt.count <= cnt.count + 1'b1;
    end
  end

  assign cnt.hit = (cnt.count == cnt.limit);
endmodule

// >>> verilog/rcis_sticky_flags.sv
`timescale 1ns/1ps
// ==================================================
// sticky flags, a set in the clear cycle wins
module rcis_sticky_flags #(
  parameter int W = 6
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clear,
  output logic      [W-1:0] o_flags
);
  // hold, clear, then set
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_flags <= '0;
    end else begin
      o_flags <= (o_flags & ~i_clear) | i_set;
    end
  end
endmodule

// >>> verilog/rcis_reset_ctrl.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - watchdog time-out asleep or idle clears only program counter and stack pointer
// - power-on reset clears watchdog time-out and power-down flags
// - low-voltage reset in fast or slow mode keeps both flags
// - run-mode watchdog time-out sets time-out flag, keeps power-down flag
// - idle or sleep watchdog time-out sets both flags
// - power-on reset disables every interrupt source
// - power-on reset clears watchdog and time base; watchdog then counts
// - power-on reset switches the timer module off
// - power-on reset makes every I/O pin an input
// - power-on reset points stack pointer at top of stack
// - qualified low voltage resets device and sets flag; software clears it
// - watchdog key 10101B or 01010B enables; others reset after delay
// - undefined threshold select resets after delay, sets flag, restores 01010101B
module rcis_reset_ctrl #(
  parameter int unsigned RSTD_CYC = rcis_pkg::RSTD_CYC,
  parameter int unsigned WDT_CYC  = rcis_pkg::WDT_CYC,
  parameter int unsigned LVR_CYC  = rcis_pkg::LVR_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [1:0]  i_power_mode,
  input  wire logic        i_low_voltage,
  input  wire logic        i_wdt_clear,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_core_hold,
  output logic             o_pc_clear,
  output logic             o_sp_clear,
  output logic             o_sp_top,
  output logic             o_int_disable,
  output logic             o_timer_off,
  output logic             o_io_input,
  output logic             o_fetch_start,
  output logic             o_time_base_tick,
  output logic             o_irq
);
  // ==================================================
  // declarations
  rcis_pkg::rcis_state_e            state;
  rcis_pkg::rcis_state_e            next_state;
  logic                             watchdog_timeout_flag;
  logic                             powerdown_flag;
  logic [7:0]                       wdt_ctrl;
  logic [7:0]                       voltage_threshold_select;
  logic [rcis_pkg::EVT_W-1:0]       evt_mask;
  logic [rcis_pkg::EVT_W-1:0]       evt_status;
  logic [rcis_pkg::EVT_W-1:0]       evt_set;
  logic [rcis_pkg::EVT_W-1:0]       evt_clear;
  logic [2:0]                       ctrl_flags;
  logic [2:0]                       ctrl_set;
  logic [2:0]                       ctrl_clear;
  logic                             full_hold;
  logic                             part_hold;
  logic                             fetch_start;
  logic                             tb_tick;
  logic [31:0]                      prdata;
  logic [31:0]                      rd_mux;
  logic [4:0]                       watchdog_enable_key;
  logic                             sleeping;
  logic                             key_ok;
  logic                             vsel_ok;
  logic                             lv_ev;
  logic                             wdt_ev;
  logic                             key_err;
  logic                             vsel_err;
  logic                             go_hold;
  logic                             go_pend;
  logic                             setup_ph;
  logic                             access_ph;
  logic                             wr_en;
  logic                             mapped;

  rcis_cnt_if #(.W(rcis_pkg::DLY_W)) dly_cnt ();
  rcis_cnt_if #(.W(rcis_pkg::WDT_W)) wdt_cnt ();
  rcis_cnt_if #(.W(rcis_pkg::LV_W))  lv_cnt ();
  rcis_cnt_if #(.W(rcis_pkg::TB_W))  tb_cnt ();

  // ==================================================
  // decoded conditions
  assign watchdog_enable_key = wdt_ctrl[7:3];
  assign sleeping = (i_power_mode == rcis_pkg::MODE_IDLE) ||
                    (i_power_mode == rcis_pkg::MODE_SLEEP);
  // only the two enable keys keep the watchdog alive
  assign key_ok   = (watchdog_enable_key == rcis_pkg::KEY_EN_A) ||
                    (watchdog_enable_key == rcis_pkg::KEY_EN_B);
  // any threshold outside the four codes is an error
  assign vsel_ok  = (voltage_threshold_select == rcis_pkg::VSEL_A) ||
                    (voltage_threshold_select == rcis_pkg::VSEL_B) ||
                    (voltage_threshold_select == rcis_pkg::VSEL_C) ||
                    (voltage_threshold_select == rcis_pkg::VSEL_D);

  // events are taken only while the core runs or waits
  assign lv_ev    = lv_cnt.hit && !o_core_hold;
  assign wdt_ev   = wdt_cnt.hit && (state == rcis_pkg::ST_RUN);
  assign key_err  = !key_ok && (state == rcis_pkg::ST_RUN);
  assign vsel_err = !vsel_ok && (state == rcis_pkg::ST_RUN);

  // ==================================================
  // low-voltage qualifier, off while asleep or idle
  assign lv_cnt.run   = i_low_voltage && !sleeping && !o_core_hold;
  assign lv_cnt.clear = !lv_cnt.run;
  assign lv_cnt.limit = rcis_pkg::LV_W'(LVR_CYC - 1);

  rcis_counter u_lv_cnt (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .cnt     (lv_cnt)
  );

  // ==================================================
  // watchdog counter, cleared by reset, instruction and expiry
  assign wdt_cnt.run   = key_ok && !o_core_hold;
  assign wdt_cnt.clear = full_hold || part_hold || i_wdt_clear || wdt_ev;
  assign wdt_cnt.limit = rcis_pkg::WDT_W'(WDT_CYC - 1);

  rcis_counter u_wdt_cnt (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .cnt     (wdt_cnt)
  );

  // ==================================================
  // time base, free running after a full reset
  assign tb_cnt.run   = 1'b1;
  assign tb_cnt.clear = full_hold || tb_cnt.hit;
  assign tb_cnt.limit = '1;

  rcis_counter u_tb_cnt (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .cnt     (tb_cnt)
  );

  // ==================================================
  // delay counter for release and software reset waits
  assign dly_cnt.run   = (state != rcis_pkg::ST_RUN);
  assign dly_cnt.clear = (next_state != state) || (state == rcis_pkg::ST_RUN);

  // limit follows the state being timed
  always_comb begin
    case (state)
      rcis_pkg::ST_HOLD: dly_cnt.limit = rcis_pkg::DLY_W'(RSTD_CYC - 1);
      rcis_pkg::ST_PEND: dly_cnt.limit = rcis_pkg::DLY_W'(rcis_pkg::SRESET_CYC - 1);
      rcis_pkg::ST_PART: dly_cnt.limit = rcis_pkg::DLY_W'(rcis_pkg::SST_CYC - 1);
      default:           dly_cnt.limit = '0;
    endcase
  end

  rcis_counter u_dly_cnt (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .cnt     (dly_cnt)
  );

  // ==================================================
  // reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      rcis_pkg::ST_RUN: begin
        if (lv_ev) begin
          next_state = rcis_pkg::ST_HOLD;
        end else if (wdt_ev && sleeping) begin
          next_state = rcis_pkg::ST_PART;
        end else if (wdt_ev) begin
          next_state = rcis_pkg::ST_HOLD;
        end else if (key_err || vsel_err) begin
          next_state = rcis_pkg::ST_PEND;
        end
      end
      rcis_pkg::ST_PEND: begin
        if (lv_ev || dly_cnt.hit) begin
          next_state = rcis_pkg::ST_HOLD;
        end
      end
      rcis_pkg::ST_HOLD: begin
        if (dly_cnt.hit) begin
          next_state = rcis_pkg::ST_RUN;
        end
      end
      rcis_pkg::ST_PART: begin
        if (dly_cnt.hit) begin
          next_state = rcis_pkg::ST_RUN;
        end
      end
      default: next_state = rcis_pkg::ST_HOLD;
    endcase
  end

  assign go_hold = (next_state == rcis_pkg::ST_HOLD) && (state != rcis_pkg::ST_HOLD);
  assign go_pend = (next_state == rcis_pkg::ST_PEND) && (state != rcis_pkg::ST_PEND);

  // state register, power-on starts in the held state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= rcis_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // reset scope levels and the release pulse
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      full_hold   <= 1'b1;
      part_hold   <= 1'b0;
      fetch_start <= 1'b0;
    end else begin
      full_hold   <= (next_state == rcis_pkg::ST_HOLD);
      part_hold   <= (next_state == rcis_pkg::ST_PART);
      fetch_start <= (state != rcis_pkg::ST_RUN) && (state != rcis_pkg::ST_PEND) &&
                     (next_state == rcis_pkg::ST_RUN);
    end
  end

  // ==================================================
  // reset effects on the core
  assign o_core_hold   = full_hold || part_hold;
  assign o_pc_clear    = full_hold || part_hold;
  assign o_sp_clear    = part_hold;
  assign o_sp_top      = full_hold;
  assign o_int_disable = full_hold;
  assign o_timer_off   = full_hold;
  assign o_io_input    = full_hold;
  assign o_fetch_start = fetch_start;

  // ==================================================
  // status flags in the core status register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
    end else if (wdt_ev) begin
      watchdog_timeout_flag <= 1'b1;
      if (sleeping) begin
        powerdown_flag <= 1'b1;
      end
    end
  end

  // time base tick pulse
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tb_tick <= 1'b0;
    end else begin
      tb_tick <= tb_cnt.hit;
    end
  end

  assign o_time_base_tick = tb_tick;

  // ==================================================
  // apb decode, zero wait states
  assign setup_ph  = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign wr_en     = access_ph && i_pwrite && mapped;
  assign mapped    = (i_paddr[1:0] == 2'h0) && (i_paddr <= rcis_pkg::ADDR_WCNT);
  assign o_pready  = 1'b1;
  assign o_pslverr = access_ph && !mapped;

  // watchdog control, back to its power-on value on a full reset
  always_ff @(posedge i_clk) begin
    if (i_reset || go_hold) begin
      wdt_ctrl <= rcis_pkg::WDT_POR;
    end else if (wr_en && i_paddr == rcis_pkg::ADDR_WDT) begin
      wdt_ctrl <= i_pwdata[7:0];
    end
  end

  // threshold select, restored on a full reset
  always_ff @(posedge i_clk) begin
    if (i_reset || go_hold) begin
      voltage_threshold_select <= rcis_pkg::VSEL_POR;
    end else if (wr_en && i_paddr == rcis_pkg::ADDR_VSEL) begin
      voltage_threshold_select <= i_pwdata[7:0];
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      evt_mask <= '0;
    end else if (wr_en && i_paddr == rcis_pkg::ADDR_MASK) begin
      evt_mask <= i_pwdata[rcis_pkg::EVT_W-1:0];
    end
  end

  // ==================================================
  // reset cause flags, cleared by writing zero
  assign ctrl_set   = {lv_ev && (state == rcis_pkg::ST_RUN || state == rcis_pkg::ST_PEND),
                       go_pend && vsel_err,
                       go_pend && key_err};
  assign ctrl_clear = (wr_en && i_paddr == rcis_pkg::ADDR_CTRL) ? ~i_pwdata[2:0] : 3'h0;

  rcis_sticky_flags #(.W(3)) u_ctrl_flags (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_set   (ctrl_set),
    .i_clear (ctrl_clear),
    .o_flags (ctrl_flags)
  );

  // ==================================================
  // interrupt events, cleared by writing one
  always_comb begin
    evt_set                        = '0;
    evt_set[rcis_pkg::EV_RELEASE]  = fetch_start;
    evt_set[rcis_pkg::EV_WDT_RUN]  = wdt_ev && !sleeping;
    evt_set[rcis_pkg::EV_WDT_IDLE] = wdt_ev && sleeping;
    evt_set[rcis_pkg::EV_LVR]      = ctrl_set[2];
    evt_set[rcis_pkg::EV_VSEL]     = ctrl_set[1];
    evt_set[rcis_pkg::EV_KEY]      = ctrl_set[0];
  end

  assign evt_clear = (wr_en && i_paddr == rcis_pkg::ADDR_EVT) ?
                     i_pwdata[rcis_pkg::EVT_W-1:0] : '0;

  rcis_sticky_flags #(.W(rcis_pkg::EVT_W)) u_evt_flags (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_set   (evt_set),
    .i_clear (evt_clear),
    .o_flags (evt_status)
  );

  // level interrupt from unmasked events
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_status & evt_mask);
    end
  end

  // ==================================================
  // read data, captured in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      rcis_pkg::ADDR_STATUS: rd_mux = {30'h0, watchdog_timeout_flag, powerdown_flag};
      rcis_pkg::ADDR_CTRL:   rd_mux = {29'h0, ctrl_flags};
      rcis_pkg::ADDR_WDT:    rd_mux = {24'h00_0000, wdt_ctrl};
      rcis_pkg::ADDR_VSEL:   rd_mux = {24'h00_0000, voltage_threshold_select};
      rcis_pkg::ADDR_EVT:    rd_mux = {26'h0, evt_status};
      rcis_pkg::ADDR_MASK:   rd_mux = {26'h0, evt_mask};
      rcis_pkg::ADDR_STATE:  rd_mux = {27'h0, key_ok, part_hold, full_hold, state};
      rcis_pkg::ADDR_WCNT:   rd_mux = {14'h0, wdt_cnt.count};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= rd_mux;
    end
  end

  assign o_prdata = prdata;
endmodule

// >>> sim/rcis_reset_ctrl_assertions.sv
`timescale 1ns/1ps
// ====================
// port checks for the reset sequencer
module rcis_reset_ctrl_assertions #(
  parameter int unsigned RSTD_CYC = 50,
  parameter int unsigned WDT_CYC  = 40,
  parameter int unsigned LVR_CYC  = 8
) (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [1:0]  i_power_mode,
  input wire logic        i_low_voltage,
  input wire logic        i_wdt_clear,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_core_hold,
  input wire logic        o_pc_clear,
  input wire logic        o_sp_clear,
  input wire logic        o_sp_top,
  input wire logic        o_int_disable,
  input wire logic        o_timer_off,
  input wire logic        o_io_input,
  input wire logic        o_fetch_start,
  input wire logic        o_time_base_tick,
  input wire logic        o_irq
);
  logic [15:0] lv_cnt;
  logic [23:0] full_cnt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // qualifying low-supply run length, and length of a full hold
  always_ff @(posedge i_clk) begin
    if (i_reset || o_core_hold || !i_low_voltage || i_power_mode[1]) begin
      lv_cnt <= 16'h0;
    end else if (lv_cnt < 16'(LVR_CYC)) begin
      lv_cnt <= lv_cnt + 16'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_sp_top) begin
      full_cnt <= 24'h0;
    end else begin
      full_cnt <= full_cnt + 24'h1;
    end
  end

  fetch_pulse_a: assert property (o_fetch_start |=> !o_fetch_start)
    else $error("fetch start longer than one cycle");
  fetch_release_a: assert property (o_fetch_start |-> !o_core_hold && $past(o_core_hold))
    else $error("fetch start not at hold release");
  full_init_a: assert property (o_sp_top |-> o_int_disable && o_timer_off && o_io_input
    && o_pc_clear && o_core_hold && !o_sp_clear)
    else $error("full reset outputs inconsistent");
  part_scope_a: assert property (o_sp_clear |-> o_pc_clear && o_core_hold && !o_sp_top
    && !o_int_disable && !o_timer_off && !o_io_input)
    else $error("partial reset touched more than pc and sp");
  hold_kind_a: assert property (o_core_hold |-> (o_sp_top ^ o_sp_clear) && o_pc_clear)
    else $error("hold without a reset kind");
  part_length_a: assert property ($rose(o_sp_clear) |-> o_sp_clear[*8] ##[1:12] o_fetch_start)
    else $error("partial hold length wrong");
  full_bound_a: assert property (full_cnt <= 24'(RSTD_CYC) + 24'h2)
    else $error("full hold too long");
  full_length_a: assert property ($fell(o_sp_top) |-> $past(full_cnt) + 24'h3 >= 24'(RSTD_CYC))
    else $error("full hold too short");
  lvr_reset_a: assert property (lv_cnt == 16'(LVR_CYC) |-> ##[0:3] o_core_hold)
    else $error("qualified low supply gave no reset");
  slverr_map_a: assert property (i_psel && i_penable |->
    o_pslverr == (i_paddr > 8'h1c || i_paddr[1:0] != 2'h0))
    else $error("slave error does not match address map");
endmodule

bind rcis_reset_ctrl rcis_reset_ctrl_assertions #(
  .RSTD_CYC(RSTD_CYC), .WDT_CYC(WDT_CYC), .LVR_CYC(LVR_CYC)
) rcis_reset_ctrl_assertions_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_power_mode(i_power_mode),
  .i_low_voltage(i_low_voltage), .i_wdt_clear(i_wdt_clear), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_core_hold(o_core_hold), .o_pc_clear(o_pc_clear), .o_sp_clear(o_sp_clear),
  .o_sp_top(o_sp_top), .o_int_disable(o_int_disable), .o_timer_off(o_timer_off),
  .o_io_input(o_io_input), .o_fetch_start(o_fetch_start),
  .o_time_base_tick(o_time_base_tick), .o_irq(o_irq)
);

// >>> sim/tb_top.sv
`timescale 1ns/1ps
// ====================
// bench for the reset cause and init block
module tb_top;
  localparam int RSTD = 50;
  localparam int SR   = rcis_pkg::SRESET_CYC;
  logic        i_clk         = 1'b0;
  logic        i_reset       = 1'b1;
  logic [1:0]  i_power_mode  = 2'h0;
  logic        i_low_voltage = 1'b0;
  logic        i_wdt_clear   = 1'b0;
  logic        i_psel        = 1'b0;
  logic        i_penable     = 1'b0;
  logic        i_pwrite      = 1'b0;
  logic [7:0]  i_paddr       = 8'h0;
  logic [31:0] i_pwdata      = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_core_hold, o_pc_clear, o_sp_clear, o_sp_top;
  logic        o_int_disable, o_timer_off, o_io_input, o_fetch_start, o_tick, o_irq;
  int          n_fail   = 0;
  int          compares = 0;
  int          cyc      = 0;
  logic [31:0] rd;
  logic        er;
  logic [15:0] ok_tab [6] = '{16'h08a8, 16'h0853, 16'h0c55, 16'h0c33, 16'h0c99, 16'h0caa};

  always #10 i_clk = ~i_clk;

  rcis_reset_ctrl #(.RSTD_CYC(RSTD), .WDT_CYC(40), .LVR_CYC(8)) rcis_reset_ctrl_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_power_mode(i_power_mode),
    .i_low_voltage(i_low_voltage), .i_wdt_clear(i_wdt_clear), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_core_hold(o_core_hold), .o_pc_clear(o_pc_clear), .o_sp_clear(o_sp_clear),
    .o_sp_top(o_sp_top), .o_int_disable(o_int_disable), .o_timer_off(o_timer_off),
    .o_io_input(o_io_input), .o_fetch_start(o_fetch_start),
    .o_time_base_tick(o_tick), .o_irq(o_irq)
  );

  // ====================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // wait for hold (0) or fetch start (1) under a cycle limit
  task automatic wait_for(input bit fetch, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((fetch ? o_fetch_start : o_core_hold) !== 1'b1 && n < lim);
    chk(32'(n < lim), 32'h1);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge i_clk);
      chk(32'({o_core_hold, o_tick}), 32'h0);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ====================
  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ====================
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    chk(32'({o_core_hold, o_pc_clear, o_sp_clear, o_sp_top}), 32'hd);
    chk(32'({o_int_disable, o_timer_off, o_io_input, o_irq}), 32'he);
    i_reset <= 1'b0;
    rchk(rcis_pkg::ADDR_STATUS, 32'h0);
    rchk(rcis_pkg::ADDR_WCNT, 32'h0);
    rchk(rcis_pkg::ADDR_WDT, 32'(rcis_pkg::WDT_POR));
    rchk(rcis_pkg::ADDR_VSEL, 32'(rcis_pkg::VSEL_POR));
    rchk(rcis_pkg::ADDR_MASK, 32'h0);
    apb(1'b0, 8'h22, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, rcis_pkg::ADDR_MASK, 32'h3f);
    wait_for(1'b1, RSTD + 20);
    chk(32'({o_core_hold, o_pc_clear, o_sp_top, o_int_disable}), 32'h0);
    apb(1'b0, rcis_pkg::ADDR_WCNT, 32'h0);
    chk(32'(rd != 32'h0), 32'h1);
    chk(32'(o_irq), 32'h1);
    // watchdog runs out in fast mode
    wait_for(1'b0, 60);
    rchk(rcis_pkg::ADDR_STATUS, 32'h2);
    rchk(rcis_pkg::ADDR_EVT, 32'h3);
    apb(1'b1, rcis_pkg::ADDR_EVT, 32'h3f);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h0);
    i_power_mode <= rcis_pkg::MODE_SLEEP;
    wait_for(1'b1, RSTD + 20);
    // watchdog runs out asleep
    wait_for(1'b0, 60);
    chk(32'({o_sp_clear, o_pc_clear, o_sp_top, o_int_disable}), 32'hc);
    rchk(rcis_pkg::ADDR_STATUS, 32'h3);
    wait_for(1'b1, 30);
    // low supply: ignored while idle and when short, then qualified
    i_wdt_clear <= 1'b1;
    apb(1'b1, rcis_pkg::ADDR_MASK, 32'h0);
    apb(1'b1, rcis_pkg::ADDR_EVT, 32'h3f);
    i_power_mode  <= rcis_pkg::MODE_IDLE;
    i_low_voltage <= 1'b1;
    quiet(12);
    i_power_mode  <= rcis_pkg::MODE_SLOW;
    i_low_voltage <= 1'b0;
    quiet(2);
    i_low_voltage <= 1'b1;
    quiet(4);
    i_low_voltage <= 1'b0;
    quiet(6);
    i_low_voltage <= 1'b1;
    wait_for(1'b0, 20);
    i_low_voltage <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h0);
    rchk(rcis_pkg::ADDR_STATUS, 32'h3);
    apb(1'b1, rcis_pkg::ADDR_CTRL, 32'h7);
    rchk(rcis_pkg::ADDR_CTRL, 32'h4);
    apb(1'b1, rcis_pkg::ADDR_MASK, 32'h8);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h1);
    apb(1'b1, rcis_pkg::ADDR_EVT, 32'h8);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h0);
    apb(1'b1, rcis_pkg::ADDR_CTRL, 32'h0);
    rchk(rcis_pkg::ADDR_CTRL, 32'h0);
    wait_for(1'b1, RSTD + 20);
    // every valid key and threshold code is kept without reset
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, ok_tab[k][15:8], 32'(ok_tab[k][7:0]));
      rchk(ok_tab[k][15:8], 32'(ok_tab[k][7:0]));
      quiet(3);
    end
    // bad key, then bad threshold code
    apb(1'b1, rcis_pkg::ADDR_WDT, 32'h3);
    quiet(SR - 100);
    wait_for(1'b0, 200);
    rchk(rcis_pkg::ADDR_CTRL, 32'h1);
    rchk(rcis_pkg::ADDR_EVT, 32'h21);
    rchk(rcis_pkg::ADDR_WDT, 32'(rcis_pkg::WDT_POR));
    apb(1'b1, rcis_pkg::ADDR_CTRL, 32'h0);
    wait_for(1'b1, RSTD + 20);
    apb(1'b1, rcis_pkg::ADDR_VSEL, 32'h12);
    quiet(SR - 100);
    wait_for(1'b0, 200);
    rchk(rcis_pkg::ADDR_CTRL, 32'h2);
    rchk(rcis_pkg::ADDR_EVT, 32'h31);
    rchk(rcis_pkg::ADDR_VSEL, 32'(rcis_pkg::VSEL_POR));
    wait_for(1'b1, RSTD + 20);
    // power-on reset again in mid-run
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk(rcis_pkg::ADDR_STATUS, 32'h0);
    wait_for(1'b1, RSTD + 20);
    final_report();
  end
endmodule
